// file: common/sacs_regs.svh
// Timing counts and field positions of the conversion sequencer
`ifndef SACS_REGS_SVH
`define SACS_REGS_SVH
`define SACS_CLK_NS 100
`define SACS_BITS 8
`define SACS_CNT_W 3
`define SACS_CYC_W 6
`define SACS_SAMPLE_EDGE 3'h3
`define SACS_LAST_EDGE 3'h7
`define SACS_HOLD_CYC 6'h04
`define SACS_CONV_CYC 6'h20
`define SACS_CONV_MAX_NS 17000
`define SACS_CONV_MAX_CYC (`SACS_CONV_MAX_NS / `SACS_CLK_NS)
`define SACS_CYCLE_22_NS 22000
`define SACS_CYCLE_25_NS 25000
`endif

// file: common/sacs_pkg.sv
// Types of the conversion sequencer
`include "sacs_regs.svh"
package sacs_pkg;
   typedef enum logic [2:0] {
      SACS_IDLE = 3'h1,
      SACS_HOLD = 3'h2,
      SACS_CONV = 3'h4
   } sacs_state_t;

   typedef struct packed {
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_s3;
      logic cs_s1;
      logic cs_s2;
      logic cs_s3;
   } sacs_sync_t;

   typedef struct packed {
      sacs_sync_t sync;
      sacs_state_t state;
      logic [`SACS_CNT_W-1:0] cnt;
      logic [`SACS_CYC_W-1:0] cyc;
      logic [`SACS_BITS-1:0] sample;
      logic [`SACS_BITS-1:0] result;
      logic dout;
      logic dout_oe;
      logic sampling;
      logic holding;
      logic busy;
      logic done;
   } sacs_st_t;
endpackage

// file: hdl/sacs_seq.sv
// Serial ADC conversion sequencer: serial shift-out, sample, hold and convert timing
//
// Behaviour
// - With select high the serial output floats and serial clock edges are ignored.
// - The first four serial clock falls shift out result bits six down to three.
// - Sampling of the analog input starts right after the fourth serial clock fall.
// - The fifth to seventh falls shift out result bits two down to zero.
// - The eighth fall starts a four-cycle hold followed by a 32-cycle conversion.
// - Select may stay low across back-to-back conversions with a glitch-free serial clock.
// - Every seen serial clock fall without a select fall in the same cycle advances the bit sequence, with no filtering.
// - A select fall before conversion ends resets the sequence and aborts the conversion.
// - A full access during a conversion aborts it, restarts, and outputs the last completed result.
// - Sampling continues until the eighth fall, which sets the capture instant.
// - The serial clock and select are independent of the system clock and are synchronised.
// - Each access both delivers the previous result and starts a new conversion.
// - A conversion completes within 17 us, well inside the 22 us and 25 us cycle times.
`include "sacs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sacs_seq (
   // System clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Serial link pins
   input wire logic sclk,
   input wire logic cs_n,
   output logic dout,
   output logic dout_oe,
   // Comparator array code
   input wire logic [`SACS_BITS-1:0] analog_code,
   // Status
   output logic sampling,
   output logic holding,
   output logic busy,
   output logic conv_done
);
   sacs_pkg::sacs_st_t st_r;
   sacs_pkg::sacs_st_t st_nxt;
   logic rst_s1_r;
   logic rst_n_r;
   logic sclk_fall;
   logic cs_fall;
   logic active;

   // Reset release through two flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // Edge detection on synchronised copies only
   assign active = ~st_r.sync.cs_s2;
   assign sclk_fall = st_r.sync.sclk_s3 & ~st_r.sync.sclk_s2 & active;
   assign cs_fall = st_r.sync.cs_s3 & ~st_r.sync.cs_s2;

   // Next-state logic
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      // Two-flop synchronisers on the link pins
      st_nxt.sync.sclk_s1 = sclk;
      st_nxt.sync.sclk_s2 = st_r.sync.sclk_s1;
      st_nxt.sync.sclk_s3 = st_r.sync.sclk_s2;
      st_nxt.sync.cs_s1 = cs_n;
      st_nxt.sync.cs_s2 = st_r.sync.cs_s1;
      st_nxt.sync.cs_s3 = st_r.sync.cs_s2;
      // Hold and conversion timing on the system clock
      case (st_r.state)
         sacs_pkg::SACS_HOLD: begin
            st_nxt.cyc = st_r.cyc + 6'h01;
            if (st_r.cyc == `SACS_HOLD_CYC - 6'h01) begin
               st_nxt.state = sacs_pkg::SACS_CONV;
               st_nxt.cyc = 6'h00;
            end
         end
         sacs_pkg::SACS_CONV: begin
            st_nxt.cyc = st_r.cyc + 6'h01;
            if (st_r.cyc == `SACS_CONV_CYC - 6'h01) begin
               st_nxt.state = sacs_pkg::SACS_IDLE;
               st_nxt.result = st_r.sample;
               st_nxt.done = 1'b1;
               st_nxt.cyc = 6'h00;
            end
         end
         default: begin
            st_nxt.state = sacs_pkg::SACS_IDLE;
            st_nxt.cyc = 6'h00;
         end
      endcase
      // Select fall resets the access and aborts any conversion
      if (cs_fall) begin
         st_nxt.cnt = '0;
         st_nxt.sampling = 1'b0;
         st_nxt.state = sacs_pkg::SACS_IDLE;
         st_nxt.cyc = 6'h00;
         st_nxt.done = 1'b0;
      end else if (sclk_fall) begin
         st_nxt.cnt = st_r.cnt + 3'h1;
         if (st_r.cnt == `SACS_SAMPLE_EDGE) begin
            st_nxt.sampling = 1'b1;
         end
         if (st_r.cnt == `SACS_LAST_EDGE) begin
            st_nxt.sampling = 1'b0;
            st_nxt.sample = analog_code;
            st_nxt.state = sacs_pkg::SACS_HOLD;
            st_nxt.cyc = 6'h00;
            st_nxt.result = st_r.result;
            st_nxt.done = 1'b0;
         end
      end
      // Pin drive from the next bit position
      st_nxt.dout_oe = ~st_r.sync.cs_s2;
      st_nxt.dout = st_nxt.result[~st_nxt.cnt];
      st_nxt.holding = (st_nxt.state == sacs_pkg::SACS_HOLD);
      st_nxt.busy = (st_nxt.state == sacs_pkg::SACS_CONV);
   end

   // State register
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_r <= '{sync: '{default: 1'b1}, state: sacs_pkg::SACS_IDLE, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign dout = st_r.dout;
   assign dout_oe = st_r.dout_oe;
   assign sampling = st_r.sampling;
   assign holding = st_r.holding;
   assign busy = st_r.busy;
   assign conv_done = st_r.done;

   // Checks
   property p_float;
      @(posedge clk) disable iff (!rst_n_r) st_r.sync.cs_s2 |=> !dout_oe;
   endproperty
   a_float: assert property (p_float) else $error("output driven while deselected");

   property p_shift;
      @(posedge clk) disable iff (!rst_n_r)
         (sclk_fall && !cs_fall) |=> (st_r.cnt == 3'($past(st_r.cnt) + 3'h1)) && dout == st_r.result[~st_r.cnt];
   endproperty
   a_shift: assert property (p_shift) else $error("bit sequence did not advance");

   property p_sample_start;
      @(posedge clk) disable iff (!rst_n_r)
         (sclk_fall && !cs_fall && st_r.cnt == 3'h3) |=> sampling && st_r.cnt == 3'h4;
   endproperty
   a_sample_start: assert property (p_sample_start) else $error("sampling did not start");

   property p_low_bits;
      @(posedge clk) disable iff (!rst_n_r)
         (sclk_fall && !cs_fall && st_r.cnt == 3'h6) |=> dout == st_r.result[0];
   endproperty
   a_low_bits: assert property (p_low_bits) else $error("last bit not shifted");

   property p_hold_conv;
      @(posedge clk) disable iff (!rst_n_r)
         (sclk_fall && !cs_fall && st_r.cnt == 3'h7) ##1 (!cs_fall && !sclk_fall) [*5]
            |-> $past(holding, 4) && $past(holding, 1) && busy;
   endproperty
   a_hold_conv: assert property (p_hold_conv) else $error("hold not four cycles");

   property p_abort;
      @(posedge clk) disable iff (!rst_n_r) cs_fall |=> !holding && !busy && st_r.cnt == 3'h0;
   endproperty
   a_abort: assert property (p_abort) else $error("select fall did not abort");

   property p_restart;
      @(posedge clk) disable iff (!rst_n_r)
         (busy && sclk_fall && !cs_fall && st_r.cnt == 3'h7) |=> holding && $stable(st_r.result);
   endproperty
   a_restart: assert property (p_restart) else $error("restart lost state");

   property p_capture;
      @(posedge clk) disable iff (!rst_n_r)
         (busy && st_r.cyc == 6'h1f && !cs_fall && !sclk_fall) |=> conv_done && st_r.result == $past(st_r.sample);
   endproperty
   a_capture: assert property (p_capture) else $error("result not loaded");

   property p_conv_time;
      @(posedge clk) disable iff (!rst_n_r)
         (holding || busy) |-> (busy ? int'(`SACS_HOLD_CYC) : 0) + int'(st_r.cyc) < `SACS_CONV_MAX_CYC;
   endproperty
   a_conv_time: assert property (p_conv_time) else $error("conversion too long");

   property p_msb;
      @(posedge clk) disable iff (!rst_n_r) cs_fall |=> dout == st_r.result[7];
   endproperty
   a_msb: assert property (p_msb) else $error("msb not presented");

   property p_ignore;
      @(posedge clk) disable iff (!rst_n_r) st_r.sync.cs_s2 |=> $stable(st_r.cnt);
   endproperty
   a_ignore: assert property (p_ignore) else $error("serial clock counted while deselected");

   property p_drive;
      @(posedge clk) disable iff (!rst_n_r) !st_r.sync.cs_s2 |=> dout_oe;
   endproperty
   a_drive: assert property (p_drive) else $error("output not driven while selected");

   property p_sample_end;
      @(posedge clk) disable iff (!rst_n_r)
         (sclk_fall && !cs_fall && st_r.cnt == 3'h7) |=> !sampling && st_r.sample == $past(analog_code);
   endproperty
   a_sample_end: assert property (p_sample_end) else $error("sample not captured at last fall");

   c_done: cover property (@(posedge clk) disable iff (!rst_n_r) conv_done);
   c_sample: cover property (@(posedge clk) disable iff (!rst_n_r) $rose(sampling));
   c_hold: cover property (@(posedge clk) disable iff (!rst_n_r) $fell(holding) && busy);
   c_restart: cover property (@(posedge clk) disable iff (!rst_n_r) busy && sclk_fall && st_r.cnt == 3'h7);
   c_abort: cover property (@(posedge clk) disable iff (!rst_n_r) busy && cs_fall);
endmodule
`default_nettype wire

// file: dv/sacs_ctrl_model.sv
// Controller model: drives select and serial clock, reads the data line
`timescale 1ns/1ps
`default_nettype none
module sacs_ctrl_model (
   // Clock and data line
   input wire logic clk,
   input wire logic dline,
   // Link pins
   output var logic sclk,
   output var logic cs_n
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
   end
   // Wait whole clocks, ending on a falling edge
   task automatic wclk(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Clean serial clocks, MSB read before each fall
   task automatic access(input int nfall, input logic rel, output logic [7:0] got);
      if (cs_n) begin
         cs_n = 1'b0;
         wclk(6);
      end
      got = 8'h00;
      for (int i = 0; i < nfall; i++) begin
         sclk = 1'b1;
         wclk(3);
         got = {got[6:0], dline};
         wclk(1);
         sclk = 1'b0;
         wclk(4);
      end
      if (rel) cs_n = 1'b1;
   endtask
   // Fast access, two clocks per phase, lands eight falls inside a conversion
   task automatic burst(input logic rel, output logic [7:0] got);
      got = 8'h00;
      for (int i = 0; i < 8; i++) begin
         sclk = 1'b1;
         wclk(1);
         got = {got[6:0], dline};
         wclk(1);
         sclk = 1'b0;
         wclk(2);
      end
      if (rel) cs_n = 1'b1;
   endtask
   // Serial clock activity with select high
   task automatic idle_clocks(input int n);
      repeat (n) begin
         sclk = 1'b1;
         wclk(4);
         sclk = 1'b0;
         wclk(4);
      end
   endtask
endmodule
`default_nettype wire

// file: dv/tb_sacs_seq.sv
// Testbench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_sacs_seq;
   logic clk, resetn, dout, dout_oe, sampling, holding, busy, conv_done;
   logic [7:0] analog_code, got, hi;
   wire logic sclk, cs_n, dline;
   int errors, n_checks, cyc, n;
   // Three-state data line
   assign dline = dout_oe ? dout : 1'bz;
   always #50 clk = ~clk;
   sacs_seq u_dut (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe),
      .analog_code(analog_code), .sampling(sampling), .holding(holding), .busy(busy), .conv_done(conv_done));
   sacs_ctrl_model u_ctrl (.clk(clk), .dline(dline), .sclk(sclk), .cs_n(cs_n));
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         conclude();
      end
   end
   task automatic chk_data(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic chk_flag(input string nm, input logic e, input logic s);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %b seen %b", nm, e, s);
      end
   endtask
   // Cycles until the result loads, bounded
   task automatic wait_done(output int k);
      k = 0;
      while (conv_done !== 1'b1 && k < 200) begin
         @(negedge clk);
         k++;
      end
      chk_flag("conv done", 1'b1, conv_done);
      u_ctrl.wclk(4);
   endtask
   // Select high: line floats, clocks ignored
   task automatic t_float();
      u_ctrl.idle_clocks(5);
      chk_flag("float", 1'bz, dline);
      chk_flag("no sampling", 1'b0, sampling);
   endtask
   // Split access, sampling window, conversion time
   task automatic t_convert();
      analog_code = 8'h5a;
      u_ctrl.access(4, 1'b0, hi);
      u_ctrl.wclk(2);
      chk_flag("sampling", 1'b1, sampling);
      u_ctrl.access(4, 1'b1, got);
      chk_data("reset result", 8'h00, {hi[3:0], got[3:0]});
      chk_flag("sampling end", 1'b0, sampling);
      chk_flag("holding", 1'b1, holding);
      chk_flag("not busy", 1'b0, busy);
      wait_done(n);
      chk_flag("conv cycles", 1'b1, n >= 33 && n <= 40);
      analog_code = 8'hc3;
      u_ctrl.access(8, 1'b1, got);
      chk_data("first result", 8'h5a, got);
      wait_done(n);
   endtask
   // Back-to-back accesses with select held low, the second inside the conversion
   task automatic t_back();
      analog_code = 8'h11;
      u_ctrl.access(8, 1'b0, got);
      chk_data("held select", 8'hc3, got);
      chk_flag("hold again", 1'b1, holding);
      analog_code = 8'h22;
      u_ctrl.burst(1'b1, got);
      chk_data("aborted conv", 8'hc3, got);
      wait_done(n);
      analog_code = 8'h33;
      u_ctrl.access(8, 1'b1, got);
      chk_data("restart result", 8'h22, got);
   endtask
   // Early select fall aborts the conversion
   task automatic t_cs_abort();
      u_ctrl.wclk(8);
      chk_flag("busy", 1'b1, busy);
      analog_code = 8'h44;
      u_ctrl.access(8, 1'b1, got);
      chk_data("abort keeps", 8'h22, got);
      wait_done(n);
      u_ctrl.access(8, 1'b1, got);
      chk_data("after abort", 8'h44, got);
      wait_done(n);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      analog_code = 8'h00;
      errors = 0;
      n_checks = 0;
      cyc = 0;
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      repeat (8) @(negedge clk);
      t_float();
      t_convert();
      t_back();
      t_cs_abort();
      conclude();
   end
endmodule
`default_nettype wire
